/* rtl/pdsm_mapper.sv */
// Program/data space address mapper with AHB-Lite control registers
`timescale 1ns/1ps
`include "pdsm_regs.svh"
module pdsm_mapper
  import pdsm_pkg::*;
#(
  parameter logic [15:0] Y_BASE   = `PDSM_Y_BASE_RST,
  parameter logic [15:0] Y_END    = `PDSM_Y_END_RST,
  parameter logic [15:0] PHYS_END = `PDSM_PHYS_END_RST
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core instruction stream
  input  wire logic        pc_step,
  input  wire logic        pc_load,
  input  wire logic [22:0] pc_target,
  output logic      [23:0] pc_addr,
  // Access request from address generation
  input  wire logic        acc_valid,
  input  wire pdsm_op_t    acc_op,
  input  wire pdsm_cls_t   acc_cls,
  input  wire logic        acc_byte,
  input  wire logic [15:0] acc_ea,
  input  wire logic        acc_mac_x,
  input  wire logic        acc_mac_y,
  input  wire logic        acc_bitrev,
  input  wire logic        in_repeat,
  input  wire logic        rep_first,
  input  wire logic        rep_last,
  input  wire logic        rep_irq_edge,
  // Program memory and data memory return words
  input  wire logic [23:0] prog_rdata,
  input  wire logic [15:0] data_rdata,
  // Mapped outputs
  output logic      [23:0] prog_addr,
  output logic             prog_sel,
  output logic             xbus_sel,
  output logic             ybus_sel,
  output logic             ybus_write,
  output logic             bitrev_ok,
  output logic      [15:0] rd_data,
  output logic      [1:0]  extra_cycles,
  output logic             acc_done
);

  localparam logic [1:0] HT_NONSEQ = 2'h2;

  logic        program_visibility_enable;
  logic [7:0]  table_page_reg;
  logic [7:0]  visibility_page_reg;
  logic        ph_wr;
  logic [31:0] ph_ofs;
  logic        sel_table;
  logic        sel_vis;
  logic        in_phys;
  logic        in_y;
  logic        zero_rd;
  logic [23:0] next_prog_addr;
  logic [15:0] next_rd_data;
  logic [1:0]  next_extra;

  // Zero-wait slave; an unmapped offset reads zero and ignores writes
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Latch the address phase of a valid transfer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ph_wr  <= 1'b0;
      ph_ofs <= 32'h00000000;
    end
    else if (hready)
    begin
      // Whole address kept so offsets above the map never alias a register
      ph_wr  <= hsel && htrans == HT_NONSEQ && hwrite;
      ph_ofs <= haddr;
    end
  end

  // Register writes in the data phase; boundary has no register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      program_visibility_enable <= 1'b0;
      table_page_reg            <= 8'h00;
      visibility_page_reg       <= 8'h00;
    end
    else if (ph_wr)
    begin
      if (ph_ofs == `PDSM_CTRL_OFS)
        program_visibility_enable <= hwdata[`PDSM_CTRL_VIS_BIT];
      else if (ph_ofs == `PDSM_TABLE_PAGE_OFS)
        table_page_reg <= hwdata[7:0];
      else if (ph_ofs == `PDSM_VIS_PAGE_OFS)
        visibility_page_reg <= hwdata[7:0];
    end
  end

  // Read data registered at the end of the address phase
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans == HT_NONSEQ && !hwrite)
    begin
      if (haddr == `PDSM_CTRL_OFS)
        hrdata <= {31'h0, program_visibility_enable};
      else if (haddr == `PDSM_TABLE_PAGE_OFS)
        hrdata <= {24'h0, table_page_reg};
      else if (haddr == `PDSM_VIS_PAGE_OFS)
        hrdata <= {24'h0, visibility_page_reg};
      else if (haddr == `PDSM_STAT_OFS)
        hrdata <= {29'h0, acc_done, prog_sel, ybus_sel};
      else
        hrdata <= 32'h00000000;
    end
  end

  // Program counter; step of two keeps bit 0 clear, bit 23 always zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pc_addr <= 24'h000000;
    else if (pc_load)
      pc_addr <= {1'b0, pc_target[22:1], 1'b0};
    else if (pc_step)
      pc_addr <= {1'b0, pc_addr[22:0] + 23'h000002};
  end

  // Region decode; Y block limits are fixed parameters
  always_comb
  begin
    sel_table = acc_op != pdsm_op_data;
    sel_vis   = !sel_table && acc_ea[`PDSM_VIS_WINDOW] &&
                program_visibility_enable;
    in_phys   = acc_ea <= PHYS_END;
    in_y      = acc_ea >= Y_BASE && acc_ea <= Y_END;
    // MAC X pointers never see Y; Y pointers only see Y or the visibility window
    zero_rd   = !sel_vis && (!in_phys ||
                (acc_mac_x && in_y) || (acc_mac_y && !in_y));
  end

  // Program address construction
  always_comb
  begin
    if (sel_table)
      next_prog_addr = {table_page_reg, acc_ea};
    else if (sel_vis)
      next_prog_addr = {1'b0, visibility_page_reg,
                        acc_ea[14:0]};
    else
      next_prog_addr = 24'h000000;
  end

  // Return data mux; top byte reaches data only on high reads
  always_comb
  begin
    next_rd_data = 16'h0000;
    case (acc_op)
      pdsm_op_table_read_low:
        if (!acc_byte)
          next_rd_data = prog_rdata[15:0];
        else if (acc_ea[0])
          next_rd_data = {8'h00, prog_rdata[15:8]};
        else
          next_rd_data = {8'h00, prog_rdata[7:0]};
      pdsm_op_table_read_high:
        if (acc_byte && acc_ea[0])
          next_rd_data = 16'h0000;
        else
          next_rd_data = {8'h00, prog_rdata[23:16]};
      pdsm_op_data:
        if (sel_vis)
          next_rd_data = prog_rdata[15:0];
        else if (zero_rd)
          next_rd_data = 16'h0000;
        else if (acc_byte)
          next_rd_data = {8'h00, acc_ea[0] ? data_rdata[15:8]
                                           : data_rdata[7:0]};
        else
          next_rd_data = data_rdata;
      default:
        next_rd_data = 16'h0000;
    endcase
  end

  // Extra cycles for a visibility access
  always_comb
  begin
    next_extra = 2'h0;
    if (sel_vis)
    begin
      if (in_repeat)
        next_extra = (rep_first || rep_last || rep_irq_edge)
                     ? `PDSM_VIS_XTRA_HI : `PDSM_VIS_XTRA_LO;
      else if (acc_cls != pdsm_cls_other)
        next_extra = `PDSM_VIS_XTRA_LO;
      else
        next_extra = `PDSM_VIS_XTRA_HI;
    end
  end

  // Registered access results, one cycle after acc_valid
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prog_addr    <= 24'h000000;
      prog_sel     <= 1'b0;
      xbus_sel     <= 1'b0;
      ybus_sel     <= 1'b0;
      ybus_write   <= 1'b0;
      bitrev_ok    <= 1'b0;
      rd_data      <= 16'h0000;
      extra_cycles <= 2'h0;
      acc_done     <= 1'b0;
    end
    else
    begin
      acc_done     <= acc_valid;
      prog_addr    <= next_prog_addr;
      prog_sel     <= acc_valid && (sel_table || sel_vis);
      xbus_sel     <= acc_valid && !sel_table && !acc_mac_y;
      ybus_sel     <= acc_valid && acc_mac_y && in_y;
      ybus_write   <= 1'b0;
      // Bit-reverse only on X data accesses; modulo needs no gating
      bitrev_ok    <= acc_valid && acc_bitrev && !acc_mac_y &&
                      (acc_op == pdsm_op_data);
      rd_data      <= acc_valid ? next_rd_data : 16'h0000;
      extra_cycles <= acc_valid ? next_extra : 2'h0;
    end
  end

  // Checks; results are looked at one cycle after the request edge
  a_pc_step_two: assert property (
    @(posedge sys_clk) disable iff (rst)
    pc_step && !pc_load |=> pc_addr[22:0] == $past(pc_addr[22:0]) + 23'h2)
    else $error("pc did not advance by two");
  a_low_word_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_table_read_low && !acc_byte
    |=> rd_data == $past(prog_rdata[15:0]))
    else $error("low table word wrong");
  a_low_byte_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_table_read_low && acc_byte
    |=> rd_data == {8'h00, $past(acc_ea[0]) ? $past(prog_rdata[15:8])
                                            : $past(prog_rdata[7:0])})
    else $error("low table byte wrong");
  a_high_word_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_table_read_high && !acc_byte
    |=> rd_data == {8'h00, $past(prog_rdata[23:16])})
    else $error("high table word wrong");
  a_high_byte_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_table_read_high && acc_byte &&
    acc_ea[0] |=> rd_data == 16'h0000)
    else $error("high byte one not zero");
  a_table_page_top: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op != pdsm_op_data
    |=> prog_addr[23:16] == $past(table_page_reg))
    else $error("table page not on top address bits");
  a_table_suspend: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op != pdsm_op_data
    |=> prog_addr[15:0] == $past(acc_ea))
    else $error("table access mapped as visibility");
  a_vis_gate_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_data &&
    !(acc_ea[`PDSM_VIS_WINDOW] && program_visibility_enable) |=> !prog_sel)
    else $error("data access redirected without visibility");
  a_vis_addr_map: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && sel_vis |=> prog_sel && prog_addr ==
    {1'b0, $past(visibility_page_reg), $past(acc_ea[14:0])})
    else $error("visibility address wrong");
  a_vis_low_word: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && sel_vis |=> rd_data == $past(prog_rdata[15:0]))
    else $error("visibility data not low program word");
  a_vis_extra_cost: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && sel_vis && !in_repeat && acc_cls == pdsm_cls_other
    |=> extra_cycles == 2'h2)
    else $error("visibility extra cost wrong");
  a_vis_extra_lo: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && sel_vis && !in_repeat && acc_cls != pdsm_cls_other
    |=> extra_cycles == 2'h1)
    else $error("visibility move cost wrong");
  a_rep_mid_cost: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && sel_vis && in_repeat && !rep_first && !rep_last &&
    !rep_irq_edge |=> extra_cycles == 2'h1)
    else $error("repeat middle cost wrong");
  a_rep_edge_cost: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && sel_vis && in_repeat &&
    (rep_first || rep_last || rep_irq_edge) |=> extra_cycles == 2'h2)
    else $error("repeat edge cost wrong");
  a_y_ptr_bus: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_data && acc_mac_y && in_y
    |=> ybus_sel && !xbus_sel)
    else $error("y pointer fetch not on y bus");
  a_mac_x_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_data && !sel_vis && acc_mac_x && in_y
    |=> rd_data == 16'h0000)
    else $error("x pointer into y not zero");
  a_mac_y_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && acc_op == pdsm_op_data && !sel_vis && acc_mac_y && !in_y
    |=> rd_data == 16'h0000)
    else $error("y pointer into x not zero");
  a_bitrev_x_only: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_valid && (acc_mac_y || acc_op != pdsm_op_data) |=> !bitrev_ok)
    else $error("bit reverse outside x space");
  a_no_y_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    !ybus_write)
    else $error("write on y bus");

endmodule // pdsm_mapper

/* shared/pdsm_pkg.sv */
// Types shared by the program/data space mapper
package pdsm_pkg;
  typedef enum logic [2:0] {
    pdsm_op_data,
    pdsm_op_table_read_low,
    pdsm_op_table_read_high,
    pdsm_op_table_write_low,
    pdsm_op_table_write_high
  } pdsm_op_t;
  typedef enum logic [1:0] {
    pdsm_cls_other,
    pdsm_cls_mac_prefetch,
    pdsm_cls_single_move,
    pdsm_cls_double_move
  } pdsm_cls_t;
endpackage

/* shared/pdsm_regs.svh */
// Address map constants and field positions for the program/data space mapper
`ifndef PDSM_REGS_SVH
`define PDSM_REGS_SVH
`define PDSM_CTRL_OFS      32'h00000000
`define PDSM_TABLE_PAGE_OFS 32'h00000004
`define PDSM_VIS_PAGE_OFS  32'h00000008
`define PDSM_STAT_OFS      32'h0000000C
`define PDSM_CTRL_VIS_BIT  0
`define PDSM_TABLE_PAGE_CFG 7
`define PDSM_VIS_WINDOW    15
`define PDSM_Y_BASE_RST    16'h0800
`define PDSM_Y_END_RST     16'h08FF
`define PDSM_PHYS_END_RST  16'h0FFF
`define PDSM_VIS_XTRA_LO   2'h1
`define PDSM_VIS_XTRA_HI   2'h2
`endif

/* verif/pdsm_mem_model.sv */
// Program and data memory model answering the mapper's reads
`timescale 1ns/1ps
module pdsm_mem_model (
  // Addresses of the current access
  input  wire logic [23:0] pm_addr,
  input  wire logic [15:0] dm_addr,
  // Returned words
  output logic      [23:0] prog_rdata,
  output logic      [15:0] data_rdata
);
  // Word content depends on the word address; top byte differs from low
  // word so a lane swap cannot go unseen
  assign prog_rdata = {pm_addr[23:16] ^ 8'hA5, pm_addr[16:1] ^ 16'h5AC3};
  assign data_rdata = dm_addr ^ 16'h3C96;
endmodule // pdsm_mem_model

/* verif/program_data_space_mapper_test.sv */
// Self-checking bench for the program/data space mapper
`timescale 1ns/1ps
`include "pdsm_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module program_data_space_mapper_test
  import pdsm_pkg::*;
;
  typedef struct packed {
    logic [15:0] rd;
    logic [15:0] m;
    logic        ps;
    logic [1:0]  ec;
    logic [23:0] pa;
    logic [2:0]  bs;
  } pdsm_note_t;
  logic        sys_clk, rst, hsel, hwrite, hready, hresp, pc_step, pc_load;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans, extra_cycles;
  logic [2:0]  hsize;
  logic [22:0] pc_target;
  logic [23:0] pc_addr, prog_rdata, pm_addr, prog_addr, w;
  logic        acc_valid, acc_byte, acc_mac_x, acc_mac_y, acc_bitrev;
  logic        in_repeat, rep_first, rep_last, rep_irq_edge, acc_done;
  logic        prog_sel, xbus_sel, ybus_sel, ybus_write, bitrev_ok;
  logic [15:0] acc_ea, data_rdata, rd_data, ea;
  logic [7:0]  pg;
  pdsm_op_t    acc_op;
  pdsm_cls_t   acc_cls;
  pdsm_note_t  q[$];
  pdsm_note_t  nt;
  int          errors, n_tests, cyc, seed, i, j;
  logic [3:0]  rp[5] = '{4'h0, 4'h8, 4'hC, 4'hA, 4'h9};
  logic [15:0] me[6] = '{16'h0820, 16'h0820, 16'h0820, 16'h0100, 16'h0100,
                         16'h1000};
  logic [1:0]  mf[6] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h0};
  logic [5:0]  mz = 6'b101010;
  logic [2:0]  mb[6] = '{3'h5, 3'h5, 3'h2, 3'h0, 3'h5, 3'h5};

  // Device under test; the one slave's ready out is the bus ready
  pdsm_mapper dut (
    .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .pc_step, .pc_load,
    .pc_target, .pc_addr, .acc_valid, .acc_op, .acc_cls, .acc_byte, .acc_ea,
    .acc_mac_x, .acc_mac_y, .acc_bitrev, .in_repeat, .rep_first, .rep_last,
    .rep_irq_edge, .prog_rdata, .data_rdata, .prog_addr, .prog_sel,
    .xbus_sel, .ybus_sel, .ybus_write, .bitrev_ok, .rd_data, .extra_cycles,
    .acc_done
  );
  // Memories on the far side
  pdsm_mem_model mem (.pm_addr, .dm_addr(acc_ea), .prog_rdata, .data_rdata);

  // Expected program word, same content as the memory model
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[23:16] ^ 8'hA5, a[16:1] ^ 16'h5AC3};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Single word transfer; address held until ready, data phase after
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    @(posedge sys_clk);
    {hsel, htrans, hwrite, hsize} <= {1'b1, 2'h2, wr, 3'h2};
    haddr <= a;
    do @(posedge sys_clk); while (hready !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  // One access; f is {byte, mac x, mac y, repeat, first, last, irq}
  task automatic go(input pdsm_op_t op, input pdsm_cls_t c,
                    input logic [6:0] f, input logic [15:0] e,
                    input pdsm_note_t n);
    logic b;
    // Random bit-reverse request; only X data accesses may honour it
    b = $random(seed);
    n.bs[0] = n.bs[0] & b;
    @(posedge sys_clk);
    {acc_valid, acc_byte, acc_mac_x, acc_mac_y, in_repeat, rep_first,
     rep_last, rep_irq_edge} <= {1'b1, f};
    acc_op <= op;
    acc_cls <= c;
    acc_ea <= e;
    pm_addr <= n.pa;
    acc_bitrev <= b;
    q.push_back(n);
    @(posedge sys_clk);
    acc_valid <= 1'b0;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard: well above the roughly 200 cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      test_done;
    end
  end

  // Scoreboard: oldest note against each completed access
  always @(posedge sys_clk)
    if (acc_done === 1'b1)
    begin
      nt = (q.size() != 0) ? q.pop_front() : '1;
      `CHK("rd_data", nt.rd, rd_data & nt.m)
      `CHK("prog_sel", nt.ps, prog_sel)
      `CHK("ybus_write", 1'b0, ybus_write)
      `CHK("bus_sel", nt.bs, {xbus_sel, ybus_sel, bitrev_ok})
      if (nt.ps)
        `CHK("prog_addr", nt.pa, prog_addr)
      if (nt.ec != 2'h3)
        `CHK("extra_cycles", nt.ec, extra_cycles)
    end

  initial
  begin
    {rst, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 72'h0};
    {pc_step, pc_load, pc_target, acc_valid, acc_byte, acc_ea} = '0;
    {acc_mac_x, acc_mac_y, acc_bitrev, pm_addr} = '0;
    {in_repeat, rep_first, rep_last, rep_irq_edge} = 4'h0;
    acc_op = pdsm_op_data;
    acc_cls = pdsm_cls_other;
    seed = 62;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // Table reads with visibility on: both read ops, both byte selects
    ahb(1'b1, `PDSM_CTRL_OFS, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      pg = $random(seed);
      pg[7] = i[0];
      ea = $random(seed) | 16'h8000;
      ahb(1'b1, `PDSM_TABLE_PAGE_OFS, {24'h0, pg});
      ahb(1'b0, `PDSM_TABLE_PAGE_OFS, 32'h0);
      `CHK("table_page_reg", {24'h0, pg}, rdv)
      `CHK("hresp", 1'b0, hresp)
      w = pw({pg, ea});
      ea[0] = 1'b0;
      go(pdsm_op_table_read_low, pdsm_cls_other, 7'h0, ea,
         '{w[15:0], 16'hFFFF, 1'b1, 2'h3, {pg, ea}, 3'h0});
      go(pdsm_op_table_read_high, pdsm_cls_other, 7'h0, ea,
         '{{8'h0, w[23:16]}, 16'hFFFF, 1'b1, 2'h3, {pg, ea}, 3'h0});
      ea[0] = i[1];
      go(pdsm_op_table_read_low, pdsm_cls_other, 7'h40, ea,
         '{{8'h0, i[1] ? w[15:8] : w[7:0]}, 16'h00FF, 1'b1, 2'h3,
           {pg, ea}, 3'h0});
      go(pdsm_op_table_read_high, pdsm_cls_other, 7'h40, ea,
         '{{8'h0, i[1] ? 8'h0 : w[23:16]}, 16'h00FF, 1'b1, 2'h3,
           {pg, ea}, 3'h0});
    end
    $display("table reads done");
    // Visibility reads over every class and repeat state
    pg = $random(seed);
    ahb(1'b1, `PDSM_VIS_PAGE_OFS, {24'h0, pg});
    for (i = 0; i < 20; i++)
    begin
      j = i % 5;
      ea = ($random(seed) | 16'h8000) & 16'hFFFE;
      w = pw({1'b0, pg, ea[14:0]});
      go(pdsm_op_data, pdsm_cls_t'(i / 5), {3'h0, rp[j]}, ea,
         '{w[15:0], 16'hFFFF, 1'b1, (j == 0) ? ((i < 5) ? 2'h2 : 2'h1)
         : ((j == 1) ? 2'h1 : 2'h2), {1'b0, pg, ea[14:0]}, 3'h5});
    end
    $display("visibility reads done");
    // Unmapped write must not move the fixed X/Y boundary
    ahb(1'b1, 32'h10, $random(seed));
    ahb(1'b0, 32'h10, 32'h0);
    `CHK("unmapped", 32'h0, rdv)
    for (i = 0; i < 6; i++)
      go(pdsm_op_data, mf[i] ? pdsm_cls_mac_prefetch : pdsm_cls_other,
         {1'b0, mf[i], 4'h0}, me[i], '{mz[i] ? 16'h0 : me[i] ^ 16'h3C96,
         16'hFFFF, 1'b0, 2'h3, 24'h0, mb[i]});
    ahb(1'b1, `PDSM_CTRL_OFS, 32'h0);
    go(pdsm_op_data, pdsm_cls_other, 7'h0, 16'h9000,
       '{16'h0, 16'hFFFF, 1'b0, 2'h3, 24'h0, 3'h5});
    $display("region checks done");
    // Program counter: load, then three single-word steps
    pc_target <= $random(seed) & 23'h3FFFFF;
    pc_load <= 1'b1;
    @(posedge sys_clk);
    pc_load <= 1'b0;
    pc_step <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pc_step <= 1'b0;
    @(posedge sys_clk);
    `CHK("pc_addr", {1'b0, pc_target[22:1], 1'b0} + 24'h6, pc_addr)
    $display("program counter done");
    repeat (3) @(posedge sys_clk);
    test_done;
  end
endmodule // program_data_space_mapper_test
